// ===== dv/fcm_clk_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Clock sources beside the monitor
// ------------------------------------------------------------------
// A stopped source freezes at its last level, which is what a lost
// oscillator looks like to the monitor.
module fcm_clk_src #(
   parameter int HALF = 4
) (
   input  wire logic clk_i,        // system clock
   input  wire logic rst_i,        // sync reset
   input  wire logic osc_run_i,    // oscillator running
   input  wire logic ref_run_i,    // external reference running
   output logic      osc_o = 1'b0, // oscillator level
   output logic      ref_o = 1'b0, // external reference level
   output logic      int_o = 1'b0  // internal reference, never lost
);
   logic [7:0] cnt_q = 8'h00;
   wire logic  wrap = (cnt_q == 8'(HALF - 1));

   always_ff @(posedge clk_i) begin
      cnt_q <= (rst_i || wrap) ? 8'h00 : cnt_q + 8'h01;
      if (wrap) begin
         int_o <= ~int_o;
         if (ref_run_i) ref_o <= ~ref_o;
      end
      if (osc_run_i) osc_o <= ~osc_o;
   end
endmodule // fcm_clk_src

// ===== dv/fcm_monitor_props.sv
`timescale 1ns/1ps
module fcm_monitor_props #(
   parameter int TIMEOUT = fcm_pkg::LOSS_CYC
) (
   input wire logic        clk_i,        // clock
   input wire logic        rst_i,        // reset
   input wire logic        ce_i,         // clock enable
   input wire logic        osc_clk_i,    // oscillator level
   input wire logic        ext_ref_i,    // reference level
   input wire logic        wb_cyc_i,     // bus cycle
   input wire logic        wb_stb_i,     // bus strobe
   input wire logic        wb_we_i,      // bus write
   input wire logic [7:0]  wb_adr_i,     // bus address
   input wire logic [3:0]  wb_sel_i,     // byte selects
   input wire logic [31:0] wb_dat_i,     // write data
   input wire logic        wb_ack_o,     // acknowledge
   input wire logic        irq_o,        // interrupt
   input wire logic        sys_reset_o,  // reset request
   input wire logic [1:0]  mode_o,       // clock mode
   input wire logic [2:0]  bypass_div_o  // bypass divider
);
   wire logic take    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
   wire logic ctrl_wr = take & wb_we_i & (wb_adr_i == fcm_pkg::CTRL_ONE_OFS);
   wire logic clr_wr  = take & wb_we_i & (wb_adr_i == fcm_pkg::GEN_STAT1_OFS)
                        & wb_sel_i[0] & wb_dat_i[fcm_pkg::IRQ_FLAG_BIT];
   logic [15:0] ext_cnt_q;
   logic [15:0] osc_cnt_q;
   logic        ext_last_q;
   logic        osc_last_q;

   // Counts how long each clock has stood still, so a mode fall-back can be
   // tied to a real loss rather than to any stray switch.
   always_ff @(posedge clk_i) begin
      ext_last_q <= ext_ref_i;
      osc_last_q <= osc_clk_i;
      ext_cnt_q  <= (rst_i || ext_ref_i != ext_last_q) ? 16'h0000 : ext_cnt_q + 16'h0001;
      osc_cnt_q  <= (rst_i || osc_clk_i != osc_last_q) ? 16'h0000 : osc_cnt_q + 16'h0001;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_reset_mode: assert property (
      $past(rst_i) |-> (mode_o == 2'b00 && !irq_o && !sys_reset_o))
      else $error("mode or flags not cleared by reset");
   a_bypass_div: assert property (
      (mode_o != 2'b11) |-> (bypass_div_o == 3'h0))
      else $error("divider shown outside bypass mode");
   a_switch_legal: assert property (
      ($changed(mode_o) && !$past(ctrl_wr)) |->
      (mode_o == 2'b00 || ($past(mode_o) == 2'b10 && mode_o == 2'b11)))
      else $error("automatic mode switch to an illegal mode");
   a_ext_loss_cause: assert property (
      (!$past(rst_i) && !$past(ctrl_wr) && $past(mode_o) == 2'b11 && mode_o == 2'b00)
      |-> (ext_cnt_q >= TIMEOUT - 1))
      else $error("bypass fall-back without reference loss");
   a_osc_loss_cause: assert property (
      (!$past(rst_i) && !$past(ctrl_wr) && (($past(mode_o) == 2'b01 && mode_o == 2'b00)
       || ($past(mode_o) == 2'b10 && mode_o == 2'b11))) |-> (osc_cnt_q >= TIMEOUT - 1))
      else $error("engaged fall-back without oscillator loss");
   a_reset_pulse: assert property (
      sys_reset_o |=> !sys_reset_o)
      else $error("reset request longer than one cycle");
   a_reset_over_irq: assert property (
      sys_reset_o |-> !$rose(irq_o))
      else $error("interrupt raised with a reset request");
   a_irq_clear_wr: assert property (
      ($fell(irq_o) && !$past(rst_i)) |-> $past(clr_wr))
      else $error("interrupt flag fell without a clear write");
endmodule // fcm_monitor_props

bind fcm_monitor fcm_monitor_props #(.TIMEOUT(TIMEOUT)) i_props (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .osc_clk_i(osc_clk_i), .ext_ref_i(ext_ref_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
   .sys_reset_o(sys_reset_o), .mode_o(mode_o), .bypass_div_o(bypass_div_o));

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        osc_run = 1'b0;
   logic        ref_run = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rd;
   logic [31:0] dat_o;
   logic        ack, irq, sysr, hold, dbl;
   logic [1:0]  mode;
   logic [2:0]  bdiv;
   wire logic   osc, ext, intr;
   int          n_mismatch = 0;
   int          checked = 0;

   fcm_clk_src #(.HALF(4)) i_src (.clk_i(clk_i), .rst_i(rst_i), .osc_run_i(osc_run),
      .ref_run_i(ref_run), .osc_o(osc), .ref_o(ext), .int_o(intr));
   // A short timeout keeps loss tests brief; it must exceed the 4-cycle half period.
   fcm_monitor #(.TIMEOUT(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .osc_clk_i(osc), .ext_ref_i(ext), .int_ref_i(intr), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .irq_o(irq), .sys_reset_o(sysr), .mode_o(mode),
      .freq_hold_o(hold), .freq_double_o(dbl), .bypass_div_o(bdiv));

   initial forever #4 clk_i = ~clk_i;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Waits for ack however long it takes; only the watchdog ends a hang.
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, ack}, 32'h0);
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task run(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task rst_dut();
      @(posedge clk_i);
      rst_i   <= 1'b1;
      osc_run <= 1'b0;
      ref_run <= 1'b1;
      run(12);
      rst_i <= 1'b0;
   endtask

   // The oscillator starts before the mode write so it is never armed while idle.
   task lock_up(input logic [31:0] ctl, input logic [31:0] ctl2);
      osc_run <= 1'b1;
      xfer(1'b1, 8'h04, ctl2);
      xfer(1'b1, 8'h00, ctl);
      run(48);
   endtask

   task pulse();
      logic seen;
      seen = 1'b0;
      repeat (30) begin
         @(posedge clk_i);
         if (sysr === 1'b1) seen = 1'b1;
      end
      chk({31'h0, seen}, 32'h1);
   endtask

   task tend(input string s);
      $display("test %s done", s);
   endtask

   task end_sim();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      rst_dut();
      chk({30'h0, mode}, 32'h0);
      rdchk(8'h00, 32'h0);
      rdchk(8'h04, 32'h00100000);
      rdchk(8'h08, 32'h2);
      rdchk(8'h0C, 32'h0);
      rdchk(8'h10, 32'h0);
      tend("reset");
      lock_up(32'h1, 32'h00040000);
      rdchk(8'h08, 32'h4A);
      rdchk(8'h0C, 32'h1);
      xfer(1'b1, 8'h04, 32'h00200000);
      run(24);
      rdchk(8'h08, 32'h53);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b0, 8'h08, 32'h0);
      xfer(1'b1, 8'h08, 32'h1);
      rdchk(8'h08, 32'h42);
      tend("lock");
      rst_dut();
      lock_up(32'h1, 32'h00040000);
      xfer(1'b1, 8'h00, 32'h0);
      run(20);
      rdchk(8'h08, 32'h2);
      xfer(1'b1, 8'h00, 32'h1);
      run(40);
      rdchk(8'h08, 32'h4A);
      xfer(1'b1, 8'h00, 32'h9);
      run(20);
      rdchk(8'h08, 32'h42);
      rdchk(8'h0C, 32'h0);
      tend("expected");
      rst_dut();
      lock_up(32'h1, 32'h00040000);
      ref_run <= 1'b0;
      run(24);
      chk({30'h0, mode}, 32'h1);
      osc_run <= 1'b0;
      run(24);
      chk({29'h0, mode, hold}, 32'h1);
      rdchk(8'h08, 32'h15);
      tend("engaged_internal");
      rst_dut();
      lock_up(32'h1, 32'h00040001);
      osc_run <= 1'b0;
      pulse();
      chk({31'h0, irq}, 32'h0);
      rdchk(8'h08, 32'h16);
      tend("precedence");
      rst_dut();
      lock_up(32'h2, 32'h00040500);
      osc_run <= 1'b0;
      run(24);
      chk({27'h0, mode, bdiv}, 32'h1D);
      rdchk(8'h08, 32'hD7);
      xfer(1'b0, 8'h08, 32'h0);
      xfer(1'b1, 8'h08, 32'h1);
      xfer(1'b1, 8'h04, 32'h00040502);
      ref_run <= 1'b0;
      pulse();
      chk({28'h0, mode, hold, dbl}, 32'h2);
      rdchk(8'h08, 32'h04);
      tend("engaged_external");
      rst_dut();
      lock_up(32'h2, 32'h00200000);
      ref_run <= 1'b0;
      run(24);
      chk({28'h0, mode, hold, dbl}, 32'h3);
      tend("double");
      rst_dut();
      lock_up(32'h5, 32'h00040000);
      osc_run <= 1'b0;
      run(24);
      chk({30'h0, mode}, 32'h1);
      xfer(1'b0, 8'h08, 32'h0);
      chk(rd & 32'h4, 32'h0);
      tend("monitor_off");
      end_sim();
   end
endmodule // testbench

// ===== src/fcm_fll.sv
`timescale 1ns/1ps
module fcm_fll #(
   parameter int MFD_W  = 8,
   parameter int LOCK   = fcm_pkg::LOCK_LIM,
   parameter int UNLOCK = fcm_pkg::UNLOCK_LIM
) (
   input  wire logic             clk_i,    // system clock
   input  wire logic             rst_i,    // sync reset
   input  wire logic             ce_i,     // clock enable
   input  wire logic             osc_i,    // oscillator level
   input  wire logic             ref_i,    // reference level
   input  wire logic             loop_i,   // loop engaged
   input  wire logic             gen_on_i, // generator on
   input  wire logic [MFD_W-1:0] mfd_i,    // multiply factor
   output fcm_pkg::fcm_fll_stat_t stat_o   // lock state
);
   localparam int W = fcm_pkg::ERR_W;

   function automatic logic inside_win(input logic signed [W-1:0] v, input int lim);
      inside_win = (v >= -W'(lim)) && (v <= W'(lim));
   endfunction

   logic                osc_q, ref_q, seen_q, lock_q, stab_q, good_q, lol_q;
   logic [W-2:0]        cnt_q;
   logic signed [W-1:0] err_q;
   wire                 osc_rise = osc_i && !osc_q;
   wire                 ref_rise = ref_i && !ref_q;
   wire  [W-2:0]        cnt_now  = cnt_q + (W-1)'(osc_rise);
   wire  signed [W-1:0] err_d    = W'(mfd_i) - W'(cnt_now);
   wire  signed [W-1:0] diff     = err_d - err_q;
   wire                 good_d   = inside_win(diff, UNLOCK);
   wire                 unlock   = lock_q && !inside_win(err_d, UNLOCK);

   assign stat_o = '{lock: lock_q, stable: stab_q, lol_evt: lol_q, err: err_q};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {osc_q, ref_q, seen_q, lock_q, stab_q, good_q, lol_q} <= '0;
         cnt_q <= '0;
         err_q <= '0;
      end else if (ce_i) begin
         osc_q <= osc_i;
         ref_q <= ref_i;
         lol_q <= 1'b0;
         if (!gen_on_i) begin
            stab_q <= 1'b0;
            good_q <= 1'b0;
         end
         if (!loop_i || !gen_on_i) begin
            lock_q <= 1'b0;
         end else if (ref_rise) begin
            if (!lock_q && inside_win(err_d, LOCK)) begin
               lock_q <= 1'b1;
            end else if (unlock) begin
               lock_q <= 1'b0;
               lol_q  <= 1'b1;
            end
         end
         if (ref_rise) begin
            err_q  <= err_d;
            cnt_q  <= '0;
            seen_q <= 1'b0;
            if (gen_on_i) begin
               good_q <= good_d;
               stab_q <= good_d && good_q && (seen_q || osc_rise);
            end
         end else begin
            cnt_q  <= cnt_now;
            seen_q <= seen_q || osc_rise;
         end
      end
   end
endmodule // fcm_fll

// ===== src/fcm_loss_det.sv
`timescale 1ns/1ps
module fcm_loss_det #(
   parameter int TIMEOUT = fcm_pkg::LOSS_CYC
) (
   input  wire logic clk_i,     // system clock
   input  wire logic rst_i,     // sync reset
   input  wire logic ce_i,      // clock enable
   input  wire logic sig_i,     // watched clock level
   input  wire logic en_i,      // detection armed
   output logic      present_o, // clock toggling
   output logic      evt_o      // one-cycle loss event
);
   localparam int CW = $clog2(TIMEOUT + 1);
   localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);

   logic          prev_q;
   logic [CW-1:0] cnt_q;
   logic          lost_q;
   logic          lost_d;
   wire           edge_seen = sig_i ^ prev_q;

   assign lost_d    = !edge_seen && (cnt_q >= LIMIT - 1'b1);
   assign present_o = !lost_q;
   // A loss only counts while armed, so idle clocks never trip it.
   assign evt_o     = ce_i && en_i && lost_d && !lost_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
         cnt_q  <= '0;
         lost_q <= 1'b0;
      end else if (ce_i) begin
         prev_q <= sig_i;
         cnt_q  <= edge_seen ? '0 : (lost_d ? cnt_q : cnt_q + 1'b1);
         lost_q <= lost_d;
      end
   end
endmodule // fcm_loss_det

// ===== src/fcm_monitor.sv
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fcm_monitor #(
   parameter int MFD_W   = 8,
   parameter int TIMEOUT = fcm_pkg::LOSS_CYC
) (
   input  wire logic        clk_i,          // system clock, 125 MHz
   input  wire logic        rst_i,          // sync reset, active high
   input  wire logic        ce_i,           // clock enable
   input  wire logic        osc_clk_i,      // controlled oscillator level
   input  wire logic        ext_ref_i,      // external reference level
   input  wire logic        int_ref_i,      // internal reference level
   input  wire logic        wb_cyc_i,       // Wishbone cycle
   input  wire logic        wb_stb_i,       // Wishbone strobe
   input  wire logic        wb_we_i,        // Wishbone write
   input  wire logic [7:0]  wb_adr_i,       // byte address
   input  wire logic [3:0]  wb_sel_i,       // byte selects
   input  wire logic [31:0] wb_dat_i,       // write data
   output logic [31:0]      wb_dat_o,       // read data
   output logic             wb_ack_o,       // acknowledge
   output logic             irq_o,          // interrupt request level
   output logic             sys_reset_o,    // reset request pulse
   output logic [1:0]       mode_o,         // current clock mode
   output logic             freq_hold_o,    // filter holds frequency
   output logic             freq_double_o,  // output frequency doubled
   output logic [2:0]       bypass_div_o    // divider in bypass mode
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef fcm_pkg::fcm_mode_t fcm_mon_mode_t;

   fcm_mon_mode_t     mode_q, mode_d;
   logic              gen_off_q, mon_dis_q, lol_re_q, loc_re_q;
   logic [2:0]        rfd_q;
   logic [MFD_W-1:0]  mfd_q;
   logic              lol_flag_q, loc_flag_q, irq_flag_q, armed_q;
   logic              hold_q, double_q, rst_req_q, ack_q;
   logic [31:0]       rdata_q;
   fcm_pkg::fcm_fll_stat_t fll_stat;
   logic              ext_present, osc_evt_raw, ext_evt_raw;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (nw & m);
   endfunction

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   wire is_fei   = (mode_q == fcm_pkg::ENGAGED_INTERNAL_MODE);
   wire is_fee   = (mode_q == fcm_pkg::ENGAGED_EXTERNAL_MODE);
   wire is_fbe   = (mode_q == fcm_pkg::BYPASSED_EXTERNAL_MODE);
   wire gen_on   = !gen_off_q;
   wire loop_on  = gen_on && (is_fei || is_fee);
   wire uses_osc = gen_on && !mon_dis_q && (is_fei || is_fee);
   wire uses_ext = gen_on && !mon_dis_q && (is_fee || is_fbe);
   wire ref_sel  = (is_fee || is_fbe) ? ext_ref_i : int_ref_i;

   // ----------------------------------------------------------------
   // Loop and clock watchers
   // ----------------------------------------------------------------
   fcm_fll #(
      .MFD_W (MFD_W)
   ) u_fll (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .osc_i    (osc_clk_i),
      .ref_i    (ref_sel),
      .loop_i   (loop_on),
      .gen_on_i (gen_on),
      .mfd_i    (mfd_q),
      .stat_o   (fll_stat)
   );

   fcm_loss_det #(
      .TIMEOUT (TIMEOUT)
   ) u_osc_loss (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .sig_i     (osc_clk_i),
      .en_i      (uses_osc),
      .present_o (),
      .evt_o     (osc_evt_raw)
   );

   fcm_loss_det #(
      .TIMEOUT (TIMEOUT)
   ) u_ext_loss (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .sig_i     (ext_ref_i),
      .en_i      (uses_ext),
      .present_o (ext_present),
      .evt_o     (ext_evt_raw)
   );

   // ----------------------------------------------------------------
   // Fault events
   // ----------------------------------------------------------------
   // A lost reference leaves no clock to bypass to, so it wins over oscillator loss.
   wire ext_loss = ext_evt_raw;
   wire osc_loss = osc_evt_raw && !ext_evt_raw;
   wire loc_evt  = ext_evt_raw || osc_evt_raw;
   wire lol_evt  = fll_stat.lol_evt || (loc_evt && loop_on);
   wire lol_rst  = lol_evt && lol_re_q;
   wire loc_rst  = loc_evt && loc_re_q;
   // A reset request overrides any interrupt raised in the same event.
   wire irq_set  = !lol_rst && !loc_rst &&
                   ((lol_evt && !lol_re_q) || (loc_evt && !loc_re_q));

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         fcm_pkg::BYPASSED_EXTERNAL_MODE: begin
            if (ext_loss) mode_d = fcm_pkg::SELF_CLOCKED_MODE;
         end
         fcm_pkg::ENGAGED_EXTERNAL_MODE: begin
            if (ext_loss) mode_d = fcm_pkg::SELF_CLOCKED_MODE;
            else if (osc_loss) mode_d = fcm_pkg::BYPASSED_EXTERNAL_MODE;
         end
         fcm_pkg::ENGAGED_INTERNAL_MODE: begin
            if (osc_loss) mode_d = fcm_pkg::SELF_CLOCKED_MODE;
         end
         default: mode_d = mode_q;
      endcase
   end

   wire auto_sw = (mode_d != mode_q);

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   wire req     = wb_cyc_i && wb_stb_i && !ack_q;
   wire wr      = req && wb_we_i;
   wire rd      = req && !wb_we_i;
   wire hit_c1  = (wb_adr_i == fcm_pkg::CTRL_ONE_OFS);
   wire hit_c2  = (wb_adr_i == fcm_pkg::GEN_CTRL2_OFS);
   wire hit_s1  = (wb_adr_i == fcm_pkg::GEN_STAT1_OFS);
   wire hit_s2  = (wb_adr_i == fcm_pkg::GEN_STAT2_OFS);

   wire [31:0] ctrl1_img = {28'h0000000, gen_off_q, mon_dis_q, mode_q};
   wire [31:0] ctrl2_img = {8'h00, 8'(mfd_q), 5'h00, rfd_q, 6'h00, loc_re_q, lol_re_q};
   wire [31:0] stat1_img = {24'h000000, mode_q, 1'b0, lol_flag_q, fll_stat.lock,
                            loc_flag_q, ext_present, irq_flag_q};
   wire [31:0] stat2_img = {31'h00000000, fll_stat.stable};
   wire [31:0] c1_new    = merge(ctrl1_img, wb_dat_i, wb_sel_i);
   wire [31:0] c2_new    = merge(ctrl2_img, wb_dat_i, wb_sel_i);
   wire        clr_wr    = wr && hit_s1 && wb_sel_i[0] && wb_dat_i[fcm_pkg::IRQ_FLAG_BIT];
   wire        clr_ok    = clr_wr && armed_q;

   wire [31:0] rd_mux = hit_c1 ? ctrl1_img :
                        hit_c2 ? ctrl2_img :
                        hit_s1 ? stat1_img :
                        hit_s2 ? stat2_img : 32'h00000000;

   assign wb_ack_o      = ack_q;
   assign wb_dat_o      = rdata_q;
   assign irq_o         = irq_flag_q;
   assign sys_reset_o   = rst_req_q;
   assign mode_o        = mode_q;
   assign freq_hold_o   = hold_q;
   assign freq_double_o = double_q;
   assign bypass_div_o  = is_fbe ? rfd_q : 3'h0;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q    <= fcm_pkg::SELF_CLOCKED_MODE;
         gen_off_q <= 1'b0;
         mon_dis_q <= 1'b0;
         lol_re_q  <= 1'b0;
         loc_re_q  <= 1'b0;
         rfd_q     <= fcm_pkg::RFD_RST;
         mfd_q     <= MFD_W'(fcm_pkg::MFD_RST);
         ack_q     <= 1'b0;
         rdata_q   <= 32'h00000000;
         armed_q   <= 1'b0;
         rst_req_q <= 1'b0;
      end else if (ce_i) begin
         ack_q     <= req;
         rst_req_q <= lol_rst || loc_rst;
         if (rd) rdata_q <= rd_mux;
         if (rd && hit_s1) armed_q <= 1'b1;
         else if (clr_wr) armed_q <= 1'b0;
         if (auto_sw) begin
            mode_q <= mode_d;
         end else if (wr && hit_c1) begin
            mode_q <= fcm_mon_mode_t'(c1_new[fcm_pkg::MODE_SEL_LSB +: 2]);
         end
         if (wr && hit_c1) begin
            mon_dis_q <= c1_new[fcm_pkg::MON_DIS_BIT];
            gen_off_q <= c1_new[fcm_pkg::GEN_OFF_BIT];
         end
         if (wr && hit_c2) begin
            lol_re_q <= c2_new[fcm_pkg::LOL_RE_BIT];
            loc_re_q <= c2_new[fcm_pkg::LOC_RE_BIT];
            rfd_q    <= c2_new[fcm_pkg::RFD_LSB +: 3];
            mfd_q    <= c2_new[fcm_pkg::MFD_LSB +: MFD_W];
         end
      end
   end

   // Sticky flags: a new event in the clearing cycle keeps the flag set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lol_flag_q <= 1'b0;
         loc_flag_q <= 1'b0;
         irq_flag_q <= 1'b0;
      end else if (ce_i) begin
         lol_flag_q <= lol_evt || (lol_flag_q && !clr_ok);
         loc_flag_q <= loc_evt || (loc_flag_q && !clr_ok);
         irq_flag_q <= irq_set || (irq_flag_q && !clr_ok);
      end
   end

   // The filter keeps the oscillator at its last setting after a fall-back to self-clocked mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_q   <= 1'b0;
         double_q <= 1'b0;
      end else if (ce_i) begin
         if (auto_sw && mode_d == fcm_pkg::SELF_CLOCKED_MODE) begin
            hold_q   <= 1'b1;
            double_q <= is_fee && !fll_stat.lock;
         end else if ((wr && hit_c1) || (auto_sw && is_fee && osc_loss)) begin
            hold_q   <= 1'b0;
            double_q <= 1'b0;
         end
      end
   end
endmodule // fcm_monitor

// ===== src/fcm_pkg.sv
// How it works
// - Count oscillator edges per reference period, subtract.
// - Lock only inside the lock acquisition window.
// - Lock clears when off, self-clocked or bypassed.
// - Leaving unlock window sets sticky lock-loss flag.
// - Expected lock loss never sets that flag.
// - Lock loss: reset if enabled, else interrupt.
// - Oscillator stable after steady errors; cleared when off.
// - Status bit shows external reference is present.
// - Bypassed external, reference lost: self-clocked, hold.
// - Engaged external, reference lost: self-clocked, hold/double.
// - Engaged external, oscillator lost: bypassed external mode.
// - Engaged internal, oscillator lost: self-clocked, hold.
// - Reset starts in self-clocked mode.
// - Automatic switch updates mode select and status.
// - Clock loss flag; reset if enabled, else interrupt.
// - Clock loss in engaged modes also loses lock.
// - Monitor disable bit turns off clock-loss detection.
package fcm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_ONE_OFS   = 8'h00;
   localparam logic [7:0] GEN_CTRL2_OFS  = 8'h04;
   localparam logic [7:0] GEN_STAT1_OFS  = 8'h08;
   localparam logic [7:0] GEN_STAT2_OFS  = 8'h0C;

   localparam int MODE_SEL_LSB   = 0;
   localparam int MON_DIS_BIT    = 2;
   localparam int GEN_OFF_BIT    = 3;
   localparam int LOL_RE_BIT     = 0;
   localparam int LOC_RE_BIT     = 1;
   localparam int RFD_LSB        = 8;
   localparam int MFD_LSB        = 16;
   localparam int IRQ_FLAG_BIT   = 0;
   localparam int EXT_STAT_BIT   = 1;
   localparam int LOC_FLAG_BIT   = 2;
   localparam int LOCK_BIT       = 3;
   localparam int LOL_FLAG_BIT   = 4;
   localparam int MODE_STAT_LSB  = 6;
   localparam int OSC_STAB_BIT   = 0;

   localparam logic [7:0] MFD_RST = 8'h10;
   localparam logic [2:0] RFD_RST = 3'h0;

   // ----------------------------------------------------------------
   // Timing and windows
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 8;
   localparam int LOSS_TIME_NS   = 1000;
   localparam int LOSS_CYC       = LOSS_TIME_NS / CLK_PERIOD_NS;
   localparam int LOCK_LIM       = 2;
   localparam int UNLOCK_LIM     = 4;
   localparam int ERR_W          = 11;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SELF_CLOCKED_MODE      = 2'b00,
      ENGAGED_INTERNAL_MODE  = 2'b01,
      ENGAGED_EXTERNAL_MODE  = 2'b10,
      BYPASSED_EXTERNAL_MODE = 2'b11
   } fcm_mode_t;

   typedef struct packed {
      logic              lock;
      logic              stable;
      logic              lol_evt;
      logic [ERR_W-1:0]  err;
   } fcm_fll_stat_t;

endpackage
